// >>> src/scm_pkg.sv
// Constants for the signal conflict fault monitor.
// Assumes a 10 MHz clock; all timing is kept in milliseconds.
package scm_pkg;

    // Register byte offsets
    localparam logic [5:0] A_CTRL     = 6'h00;
    localparam logic [5:0] A_RF_EN    = 6'h04;
    localparam logic [5:0] A_CLR_EN   = 6'h08;
    localparam logic [5:0] A_DUAL_EN  = 6'h0c;
    localparam logic [5:0] A_YEL_INH  = 6'h10;
    localparam logic [5:0] A_STATUS   = 6'h14;
    localparam logic [5:0] A_CH_FAULT = 6'h18;
    localparam logic [5:0] A_CH_ON    = 6'h1c;

    // Control fields and reset value
    localparam int         C_TYPE   = 0;
    localparam int         C_GY     = 1;
    localparam int         C_ARROW  = 2;
    localparam int         C_LAYOUT = 3;
    localparam int         CTRL_W   = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic       EN_RST   = 1'h1;

    // Status fields
    localparam int S_RF    = 0;
    localparam int S_CLR   = 1;
    localparam int S_DUAL  = 2;
    localparam int S_CFG   = 3;
    localparam int S_WD    = 4;
    localparam int S_BROWN = 5;
    localparam int S_START = 6;
    localparam int S_ANY   = 7;
    localparam int S_STATE = 8;

    // Arrow pairing: four pairs, arrow channels from index 8
    localparam int ARROW_BASE = 8;
    localparam int ARROW_PAIRS = 4;

    // Timebase
    localparam int CLK_HZ  = 10_000_000;
    localparam int TICK_HZ = 1_000;

    // Times in ms
    localparam logic [11:0] AUX_ON_MS   = 12'h226; // 550 ms
    localparam logic [11:0] SIG_ON_MS   = 12'h1f4; // 500 ms
    localparam logic [11:0] RF_MS_A     = 12'h352; // 850 ms
    localparam logic [11:0] RF_MS_B     = 12'h546; // 1350 ms
    localparam logic [11:0] CLR_MS      = 12'ha8c; // 2700 ms
    localparam logic [11:0] DUAL_MS     = 12'h15e; // 350 ms
    localparam logic [11:0] CFG_HOLD_MS = 12'hbb8; // 3000 ms
    localparam logic [13:0] START_MIN_MS = 14'h1770; // 6000 ms
    localparam logic [13:0] START_MAX_MS = 14'h2710; // 10000 ms
    localparam logic [8:0]  BLINK_PER_MS = 9'h1f4; // 500 ms
    localparam logic [8:0]  BLINK2_HALF  = 9'h0fa; // 250 ms
    localparam logic [8:0]  BLINK4_HALF  = 9'h07d; // 125 ms
    localparam logic [2:0]  HB_NEED      = 3'h5;

    typedef enum logic [1:0] {
        ST_START = 2'h0,
        ST_RUN   = 2'h1,
        ST_BROWN = 2'h3
    } scm_state_t;

endpackage

// >>> src/scm_monitor.sv
// Fault detection and latching core of the signal conflict monitor.
// Assumes field inputs are already digitised levels synchronous to clk
// and that software reaches the registers over Avalon-MM.
//
// Function
// - Active auxiliary inhibit stops red-fail checking only.
// - Inhibit active after 550 ms high; inactive when low.
// - Red on after 500 ms high; off when low.
// - Green and yellow qualify with the same 500 ms timing.
// - Any fault except config latches until front panel or remote reset.
// - Channel with no indication past limit triggers red-fail.
// - No red-fail when no indication is shorter than lower limit.
// - Red-fail check enabled per channel.
// - Red-fail needs red-check enable, no inhibit, relay sense off.
// - Yellow under 2.7 s after green triggers clearance fault.
// - Clearance per channel; suppressed by inhibit, enable, sense.
// - Dual indication over limit triggers; never below 200 ms.
// - Per channel all-colour dual, global green-yellow dual.
// - Configuration compared with stored copy; mismatch triggers.
// - Config fault clears only by 3 s front reset hold.
// - Line low triggers and blinks power indicator at 2 Hz.
// - Line restore restarts the start-up interval with 4 Hz indicator.
// - Latched faults survive a line power interruption.
// - Start-up interval suspends checks, closes relay, 4 Hz blink.
// - Start-up ends after 6 s, 5 heartbeat edges, line restored.
// - Missing heartbeat edges by 10 s gives heartbeat fault.
// - Layout switch picks arrow pairing; pairs checked jointly.
`timescale 1ns/1ps

module scm_monitor
    import scm_pkg::*;
#(
    parameter int N_CH     = 18,
    parameter int CFG_W    = 16,
    parameter int TICK_CYC = CLK_HZ / TICK_HZ
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [5:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic [N_CH-1:0]  red_in,
    input  wire logic [N_CH-1:0]  yel_in,
    input  wire logic [N_CH-1:0]  grn_in,
    input  wire logic [1:0]       aux_inhibit_in,
    input  wire logic             red_check_en_in,
    input  wire logic             relay_common_sense,
    input  wire logic             controller_heartbeat,
    input  wire logic             front_reset,
    input  wire logic             remote_reset,
    input  wire logic             line_volt_low,
    input  wire logic             line_volt_restore,
    input  wire logic [CFG_W-1:0] config_in,
    output logic                  relay_closed,
    output logic                  force_flash,
    output logic                  power_led,
    output logic                  card_led,
    output logic      [N_CH-1:0]  ch_fault_led
);

    localparam int NS    = 3 * N_CH + 2;
    localparam int CUR_W = CTRL_W + 4 * N_CH + CFG_W;

    ////////////////////////////////////////////////////////////////////
    // Millisecond timebase and blink patterns

    logic [13:0] div_q;
    logic [8:0]  bl_q;
    wire         tick   = div_q == 14'(TICK_CYC - 1);
    wire         blink2 = bl_q < BLINK2_HALF;
    wire         blink4 = (bl_q < BLINK4_HALF) ||
                          (bl_q >= BLINK2_HALF &&
                           bl_q < BLINK2_HALF + BLINK4_HALF);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            bl_q  <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 14'h1;
            if (tick) begin
                bl_q <= (bl_q == BLINK_PER_MS - 9'h1) ? '0 : bl_q + 9'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input qualification: on only after a held high level

    wire [NS-1:0] raw = {aux_inhibit_in, grn_in, yel_in, red_in};
    logic [NS-1:0] on;

    for (genvar i = 0; i < NS; i++) begin : g_q
        localparam logic [11:0] THR = (i >= 3 * N_CH) ? AUX_ON_MS
                                                       : SIG_ON_MS;
        logic [11:0] qc_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                qc_q <= '0;
            end else if (!raw[i]) begin
                qc_q <= '0;
            end else if (tick && qc_q < THR) begin
                qc_q <= qc_q + 12'h1;
            end
        end
        assign on[i] = raw[i] && qc_q >= THR;
    end

    wire [N_CH-1:0] red_on = on[N_CH-1:0];
    wire [N_CH-1:0] yel_on = on[2*N_CH-1:N_CH];
    wire [N_CH-1:0] grn_on = on[3*N_CH-1:2*N_CH];
    wire            aux_on = |on[NS-1:NS-2];

    ////////////////////////////////////////////////////////////////////
    // Registers and bus slave

    logic [CTRL_W-1:0] ctrl_q;
    logic [N_CH-1:0]   rf_en_q;
    logic [N_CH-1:0]   clr_en_q;
    logic [N_CH-1:0]   dual_en_q;
    logic [N_CH-1:0]   yel_inh_q;
    logic              ack_q;
    logic [31:0]       rd_q;
    logic [31:0]       stat;

    scm_state_t state_q;
    logic [N_CH-1:0] rf_flt_q;
    logic [N_CH-1:0] cl_flt_q;
    logic [N_CH-1:0] du_flt_q;
    logic            cfg_flt_q;
    logic            wd_flt_q;

    wire req = avs_read || avs_write;
    wire wr  = avs_write && ack_q;
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata    = rd_q;

    wire [31:0] rmux =
        (avs_address == A_CTRL)     ? 32'(ctrl_q)   :
        (avs_address == A_RF_EN)    ? 32'(rf_en_q)  :
        (avs_address == A_CLR_EN)   ? 32'(clr_en_q) :
        (avs_address == A_DUAL_EN)  ? 32'(dual_en_q) :
        (avs_address == A_YEL_INH)  ? 32'(yel_inh_q) :
        (avs_address == A_STATUS)   ? stat :
        (avs_address == A_CH_FAULT) ? 32'(ch_fault_led) :
        (avs_address == A_CH_ON)    ? 32'(red_on | yel_on | grn_on) :
        32'h0;

    always_comb begin
        stat          = '0;
        stat[S_RF]    = |rf_flt_q;
        stat[S_CLR]   = |cl_flt_q;
        stat[S_DUAL]  = |du_flt_q;
        stat[S_CFG]   = cfg_flt_q;
        stat[S_WD]    = wd_flt_q;
        stat[S_BROWN] = state_q == ST_BROWN;
        stat[S_START] = state_q == ST_START;
        stat[S_ANY]   = force_flash;
        stat[S_STATE +: 2] = state_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q     <= 1'b0;
            rd_q      <= '0;
            ctrl_q    <= CTRL_RST;
            rf_en_q   <= {N_CH{EN_RST}};
            clr_en_q  <= {N_CH{EN_RST}};
            dual_en_q <= {N_CH{EN_RST}};
            yel_inh_q <= '0;
        end else begin
            ack_q <= req && !ack_q;
            if (avs_read && !ack_q) begin
                rd_q <= rmux;
            end
            if (wr && avs_address == A_CTRL) begin
                ctrl_q <= avs_writedata[CTRL_W-1:0];
            end
            if (wr && avs_address == A_RF_EN) begin
                rf_en_q <= avs_writedata[N_CH-1:0];
            end
            if (wr && avs_address == A_CLR_EN) begin
                clr_en_q <= avs_writedata[N_CH-1:0];
            end
            if (wr && avs_address == A_DUAL_EN) begin
                dual_en_q <= avs_writedata[N_CH-1:0];
            end
            if (wr && avs_address == A_YEL_INH) begin
                yel_inh_q <= avs_writedata[N_CH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-channel checks

    function automatic int pair_of(int ch, bit lay);
        int p;
        p = ch;
        if (ch < ARROW_BASE && ch % 2 == 0) begin
            p = lay ? ARROW_BASE + ch / 4 : ARROW_BASE + ch / 2;
        end else if (ch >= ARROW_BASE && ch < ARROW_BASE + ARROW_PAIRS) begin
            if (!lay) begin
                p = 2 * (ch - ARROW_BASE);
            end else if (ch < ARROW_BASE + 2) begin
                p = 4 * (ch - ARROW_BASE);
            end
        end
        return (p < N_CH) ? p : ch;
    endfunction

    wire checks_on = state_q == ST_RUN && red_check_en_in &&
                     !relay_common_sense;
    wire [11:0] rf_thr = ctrl_q[C_TYPE] ? RF_MS_B : RF_MS_A;
    wire clr_req = front_reset || remote_reset;

    logic [1:0]      n_on [N_CH];
    logic [N_CH-1:0] rf_set;
    logic [N_CH-1:0] cl_set;
    logic [N_CH-1:0] du_set;

    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        localparam int PS = pair_of(c, 1'b0);
        localparam int PC = pair_of(c, 1'b1);
        logic [11:0] nc_q;
        logic [11:0] dc_q;
        logic [11:0] yc_q;
        logic        pend_q;
        logic        gd_q;

        assign n_on[c] = 2'(red_on[c]) + 2'(yel_on[c]) + 2'(grn_on[c]);
        wire [1:0] n_pt = ctrl_q[C_LAYOUT] ? n_on[PC] : n_on[PS];
        wire       paired = ctrl_q[C_ARROW] &&
                            (ctrl_q[C_LAYOUT] ? PC != c : PS != c);
        wire [2:0] n_all = 3'(n_on[c]) +
                           (paired ? 3'(n_pt) : 3'h0);
        wire rf_gate = checks_on && !aux_on && rf_en_q[c];
        wire multi = (dual_en_q[c] && n_all >= 3'h2) ||
                     (ctrl_q[C_GY] && grn_on[c] && yel_on[c]);
        wire cl_gate = checks_on && clr_en_q[c] && !yel_inh_q[c];

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                nc_q <= '0;
                dc_q <= '0;
            end else begin
                if (!rf_gate || n_all != 3'h0) begin
                    nc_q <= '0;
                end else if (tick && nc_q < rf_thr) begin
                    nc_q <= nc_q + 12'h1;
                end
                if (!checks_on || !multi) begin
                    dc_q <= '0;
                end else if (tick && dc_q < DUAL_MS) begin
                    dc_q <= dc_q + 12'h1;
                end
            end
        end

        // Yellow is timed on the raw level so qualification delay
        // does not eat into the 2.7 s window.
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                gd_q   <= 1'b0;
                pend_q <= 1'b0;
                yc_q   <= '0;
            end else begin
                gd_q <= grn_on[c];
                if (!cl_gate) begin
                    pend_q <= 1'b0;
                    yc_q   <= '0;
                end else if (gd_q && !grn_on[c]) begin
                    pend_q <= 1'b1;
                    yc_q   <= '0;
                end else if (cl_set[c]) begin
                    // Drop the pending check once it fires, else a reset
                    // could never clear the latch while red stays on
                    pend_q <= 1'b0;
                end else if (pend_q && yc_q >= CLR_MS) begin
                    pend_q <= 1'b0;
                end else if (pend_q && yel_in[c] && tick) begin
                    yc_q <= yc_q + 12'h1;
                end
            end
        end

        assign rf_set[c] = rf_gate && nc_q >= rf_thr;
        assign du_set[c] = checks_on && dc_q >= DUAL_MS;
        assign cl_set[c] = pend_q && yc_q < CLR_MS && !yel_in[c] &&
                           (red_on[c] || grn_on[c]);
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration compare

    logic [CUR_W-1:0] stored_q;
    logic             stored_vld_q;
    logic [11:0]      fr_ms_q;
    wire [CUR_W-1:0]  cur_cfg = {ctrl_q, rf_en_q, clr_en_q, dual_en_q,
                                 yel_inh_q, config_in};
    wire cfg_acc = fr_ms_q >= CFG_HOLD_MS;
    wire cfg_set = stored_vld_q && tick && cur_cfg != stored_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stored_q     <= '0;
            stored_vld_q <= 1'b0;
            fr_ms_q      <= '0;
        end else begin
            if (!front_reset) begin
                fr_ms_q <= '0;
            end else if (tick && !cfg_acc) begin
                fr_ms_q <= fr_ms_q + 12'h1;
            end
            if (cfg_acc || (!stored_vld_q && state_q == ST_RUN)) begin
                stored_q     <= cur_cfg;
                stored_vld_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power state and start-up interval

    logic [13:0] st_ms_q;
    logic [2:0]  hb_cnt_q;
    logic        hb_d_q;
    wire hb_edge  = hb_d_q != controller_heartbeat;
    wire st_done  = st_ms_q >= START_MIN_MS && hb_cnt_q >= HB_NEED &&
                    line_volt_restore;
    wire st_tmo   = st_ms_q >= START_MAX_MS;
    wire wd_set   = state_q == ST_START && st_tmo &&
                    hb_cnt_q < HB_NEED;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q  <= ST_START;
            st_ms_q  <= '0;
            hb_cnt_q <= '0;
            hb_d_q   <= 1'b0;
        end else begin
            hb_d_q <= controller_heartbeat;
            case (state_q)
                ST_START: begin
                    if (tick && !st_tmo) begin
                        st_ms_q <= st_ms_q + 14'h1;
                    end
                    if (hb_edge && hb_cnt_q < HB_NEED) begin
                        hb_cnt_q <= hb_cnt_q + 3'h1;
                    end
                    if (line_volt_low) begin
                        state_q <= ST_BROWN;
                    end else if (st_done || st_tmo) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (line_volt_low) begin
                        state_q <= ST_BROWN;
                    end
                end
                default: begin
                    if (line_volt_restore && !line_volt_low) begin
                        state_q  <= ST_START;
                        st_ms_q  <= '0;
                        hb_cnt_q <= '0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault latches and indicators
    // Brown-out touches only power_led here, so the fault latches ride through it.

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rf_flt_q     <= '0;
            cl_flt_q     <= '0;
            du_flt_q     <= '0;
            cfg_flt_q    <= 1'b0;
            wd_flt_q     <= 1'b0;
            power_led    <= 1'b0;
            card_led     <= 1'b0;
            ch_fault_led <= '0;
        end else begin
            rf_flt_q  <= (rf_flt_q & ~{N_CH{clr_req}}) | rf_set;
            cl_flt_q  <= (cl_flt_q & ~{N_CH{clr_req}}) | cl_set;
            du_flt_q  <= (du_flt_q & ~{N_CH{clr_req}}) | du_set;
            wd_flt_q  <= (wd_flt_q && !clr_req) || wd_set;
            cfg_flt_q <= (cfg_flt_q && !cfg_acc) || cfg_set;
            card_led  <= cfg_flt_q && blink2;
            ch_fault_led <= rf_flt_q | cl_flt_q | du_flt_q;
            case (state_q)
                ST_START: power_led <= blink4;
                ST_RUN:   power_led <= 1'b1;
                default:  power_led <= blink2;
            endcase
        end
    end

    wire any_fault = |{rf_flt_q, cl_flt_q, du_flt_q, cfg_flt_q, wd_flt_q};
    assign relay_closed = state_q == ST_START ||
                          (state_q == ST_RUN && !any_fault);
    assign force_flash  = !relay_closed;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_start_exit;
        state_q == ST_START ##1 state_q == ST_RUN;
    endsequence

    sequence s_brown_hold;
        state_q == ST_BROWN ##1 state_q == ST_BROWN;
    endsequence

    property p_aux_inhibit;
        aux_on && $past(aux_on) |-> (rf_flt_q & ~$past(rf_flt_q)) == '0;
    endproperty
    a_aux_inhibit: assert property (p_aux_inhibit)
        else $error("red-fail latched while inhibit active");

    property p_rf_time;
        $rose(rf_flt_q[0]) |-> $past(g_ch[0].nc_q) >= RF_MS_A;
    endproperty
    a_rf_time: assert property (p_rf_time)
        else $error("red-fail set before its minimum time");

    property p_dual_time;
        $rose(du_flt_q[0]) |-> $past(g_ch[0].dc_q) >= DUAL_MS;
    endproperty
    a_dual_time: assert property (p_dual_time)
        else $error("dual indication set too early");

    property p_latch;
        rf_flt_q[0] && !clr_req |=> rf_flt_q[0];
    endproperty
    a_latch: assert property (p_latch)
        else $error("red-fail dropped without a reset");

    property p_cfg_clear;
        $fell(cfg_flt_q) |-> $past(fr_ms_q) >= CFG_HOLD_MS;
    endproperty
    a_cfg_clear: assert property (p_cfg_clear)
        else $error("config fault cleared without long hold");

    property p_start_min;
        s_start_exit |-> $past(st_ms_q) >= START_MIN_MS;
    endproperty
    a_start_min: assert property (p_start_min)
        else $error("start-up ended before minimum time");

    property p_wd_fault;
        state_q == ST_START && st_tmo && hb_cnt_q < HB_NEED |=> wd_flt_q;
    endproperty
    a_wd_fault: assert property (p_wd_fault)
        else $error("missing heartbeat fault not raised");

    property p_brown_led;
        s_brown_hold |-> power_led == $past(blink2) && !relay_closed;
    endproperty
    a_brown_led: assert property (p_brown_led)
        else $error("brown-out indication wrong");

    property p_restore;
        state_q == ST_BROWN && line_volt_restore && !line_volt_low
            |=> state_q == ST_START ##1 relay_closed;
    endproperty
    a_restore: assert property (p_restore)
        else $error("restore did not start the interval");

    property p_start_relay;
        state_q == ST_START |-> relay_closed && !checks_on;
    endproperty
    a_start_relay: assert property (p_start_relay)
        else $error("start-up interval did not hold relay");

endmodule

// >>> tb/scm_partner.sv
// Controller model: makes the heartbeat level changes on request.
// Assumes the bench clock; one change every 256 cycles, five in all.
`timescale 1ns/1ps
module scm_partner (
    input  wire logic clk,
    input  wire logic go,
    output logic      controller_heartbeat
);
    logic [7:0] div_q = 8'h00;
    logic [3:0] n_q   = 4'h0;
    logic       hb_q  = 1'h0;
    assign controller_heartbeat = hb_q;
    // Exactly five changes, well inside start-up, then hold still
    always @(posedge clk) begin
        if (go && n_q < 4'h5) begin
            div_q <= div_q + 8'h01;
            if (div_q == 8'hff) begin
                hb_q <= ~hb_q;
                n_q  <= n_q + 4'h1;
            end
        end
    end
endmodule

// >>> tb/scm_monitor_tb.sv
// Bench for the conflict monitor: bus tasks and timed field stimulus.
// Assumes TICK_CYC of 10, so one millisecond is ten clock cycles.
`timescale 1ns/1ps
module scm_monitor_tb
    import scm_pkg::*;
();
    localparam int TC = 10;
    logic        clk;
    logic        rst;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [17:0] red_in;
    logic [17:0] grn_in;
    logic        hb;
    logic        hb_go;
    logic        front_reset;
    logic        remote_reset;
    logic        line_volt_low;
    logic [15:0] config_in;
    logic        relay_closed;
    logic        force_flash;
    logic        power_led;
    logic        card_led;
    logic        line_volt_restore;
    logic [31:0] q;
    int          n_fail;
    int          checks_done;
    ////////////////////////////////////////////////////////////////////////
    scm_monitor #(.TICK_CYC(TC)) scm_monitor_inst (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .red_in(red_in),
        .yel_in(18'h0), .grn_in(grn_in), .aux_inhibit_in(2'h0),
        .red_check_en_in(1'h1), .relay_common_sense(1'h0),
        .controller_heartbeat(hb), .front_reset(front_reset),
        .remote_reset(remote_reset), .line_volt_low(line_volt_low),
        .line_volt_restore(line_volt_restore), .config_in(config_in),
        .relay_closed(relay_closed), .force_flash(force_flash),
        .power_led(power_led), .card_led(card_led), .ch_fault_led());
    scm_partner scm_partner_inst (
        .clk(clk), .go(hb_go), .controller_heartbeat(hb));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Request held until waitrequest is seen low; the wait is bounded
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= ~w;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (avs_waitrequest !== 1'h0 && i < 50);
        if (avs_waitrequest !== 1'h0) begin
            n_fail++;
            finish_test();
        end
        // Answer is settled mid-cycle and taken there, at the falling edge
        r = avs_readdata;
        @(posedge clk);
        avs_read  <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    task automatic wt(input int ms);
        repeat (ms * TC) @(posedge clk);
    endtask
    task automatic pulse_remote();
        remote_reset <= 1'h1;
        wt(1);
        remote_reset <= 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'h1;
        avs_address = 6'h00;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        red_in = 18'h3ffff;
        grn_in = 18'h0;
        hb_go = 1'h0;
        front_reset = 1'h0;
        remote_reset = 1'h0;
        line_volt_low = 1'h0;
        line_volt_restore = 1'h1;
        config_in = 16'h0;
        n_fail = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        hb_go <= 1'h1;
        rd(A_CTRL, 32'hffffffff, 32'h0);
        rd(A_RF_EN, 32'hffffffff, 32'h3ffff);
        bus(1'h1, A_YEL_INH, 32'h2, q);
        rd(A_YEL_INH, 32'hffffffff, 32'h2);
        bus(1'h1, 6'h20, 32'h5, q);
        rd(6'h20, 32'hffffffff, 32'h0);
        chk(32'(relay_closed), 32'h1);
        chk(32'(card_led), 32'h0);
        wt(5900);
        rd(A_STATUS, 32'h300, 32'h0);
        wt(150);
        rd(A_STATUS, 32'h300, 32'h100);
        chk(32'(power_led), 32'h1);
        // Short gap: 100 ms low plus 500 ms to requalify stays below 850 ms
        red_in[0] <= 1'h0;
        wt(100);
        red_in[0] <= 1'h1;
        wt(600);
        rd(A_STATUS, 32'h1, 32'h0);
        red_in[0] <= 1'h0;
        wt(1100);
        rd(A_STATUS, 32'h1, 32'h1);
        rd(A_CH_FAULT, 32'h3ffff, 32'h1);
        chk(32'(force_flash), 32'h1);
        red_in[0] <= 1'h1;
        wt(600);
        rd(A_STATUS, 32'h1, 32'h1);
        pulse_remote();
        rd(A_STATUS, 32'h1, 32'h0);
        // Green on channels 1 and 2 qualifies after 500 ms over red
        grn_in[2:1] <= 2'h3;
        wt(1100);
        rd(A_STATUS, 32'h6, 32'h4);
        // Green ends with red on and no yellow: clearance on channel 2
        grn_in[2:1] <= 2'h0;
        wt(1);
        rd(A_STATUS, 32'h6, 32'h6);
        rd(A_CH_FAULT, 32'h3ffff, 32'h6);
        front_reset <= 1'h1;
        wt(1);
        front_reset <= 1'h0;
        rd(A_STATUS, 32'h6, 32'h0);
        config_in <= 16'h0001;
        wt(5);
        rd(A_STATUS, 32'h8, 32'h8);
        pulse_remote();
        rd(A_STATUS, 32'h8, 32'h8);
        line_volt_low <= 1'h1;
        line_volt_restore <= 1'h0;
        wt(5);
        rd(A_STATUS, 32'h308, 32'h308);
        chk(32'(relay_closed), 32'h0);
        line_volt_low <= 1'h0;
        line_volt_restore <= 1'h1;
        wt(5);
        rd(A_STATUS, 32'h348, 32'h48);
        chk(32'(relay_closed), 32'h1);
        finish_test();
    end
endmodule
